// File: pkg/positioner_pkg.sv
package positioner_pkg;

	// Clock rate and the default interval between two microsteps.
	localparam int CLK_FREQ_HZ      = 20_000_000;
	localparam int STEP_PERIOD_US   = 1000;
	localparam int STEP_DIV_CYCLES  = STEP_PERIOD_US * (CLK_FREQ_HZ / 1_000_000);

	// Register byte offsets on the AXI4-Lite port.
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_CFG        = 8'h04;
	localparam logic [7:0] OFF_MOVE_DIST  = 8'h08;
	localparam logic [7:0] OFF_STEPS_UNIT = 8'h0C;
	localparam logic [7:0] OFF_BACKLASH   = 8'h10;
	localparam logic [7:0] OFF_HOME_OFS   = 8'h14;
	localparam logic [7:0] OFF_STEP_DIV   = 8'h18;
	localparam logic [7:0] OFF_STEPS_REV  = 8'h1C;
	localparam logic [7:0] OFF_POSITION   = 8'h20;
	localparam logic [7:0] OFF_REPORT     = 8'h24;
	localparam logic [7:0] OFF_STATUS     = 8'h28;
	localparam logic [7:0] OFF_IRQ_STAT   = 8'h2C;
	localparam logic [7:0] OFF_IRQ_CLR    = 8'h30;
	localparam logic [7:0] OFF_IRQ_EN     = 8'h34;

	// Command bits of the control register (write one to issue).
	localparam int CTRL_MOVE   = 0;
	localparam int CTRL_HOME   = 1;
	localparam int CTRL_STOP   = 2;
	localparam int CTRL_REPORT = 3;

	// Configuration bits.
	localparam int CFG_BACKLASH = 0;
	localparam int CFG_ROTARY   = 1;

	// Status bits.
	localparam int STAT_BUSY     = 0;
	localparam int STAT_HOMED    = 1;
	localparam int STAT_REP_BUSY = 2;
	localparam int STAT_LIMIT    = 3;
	localparam int STAT_DIR      = 4;

	// Interrupt event bits.
	localparam int IRQ_MOVE_DONE = 0;
	localparam int IRQ_HOME_DONE = 1;
	localparam int IRQ_LIMIT     = 2;
	localparam int IRQ_REPORT    = 3;
	localparam int IRQ_W         = 4;

	// Values after reset.
	localparam logic [31:0] CFG_RESET        = 32'h00000001;
	localparam logic [31:0] STEPS_UNIT_RESET = 32'h00000800;
	localparam logic [31:0] BACKLASH_RESET   = 32'h00000400;
	localparam logic [31:0] HOME_OFS_RESET   = 32'h00000800;
	localparam logic [31:0] STEPS_REV_RESET  = 32'h00064000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum {MOT_IDLE, MOT_MOVE, MOT_SEEK, MOT_OFFSET} motion_state_t;
	typedef enum {REP_IDLE, REP_WRAP, REP_SCALE} report_state_t;

endpackage

// File: hw/pos_divider.sv
`timescale 1ns/1ps
// Signed dividend over unsigned divisor, floor quotient and non-negative remainder.
module pos_divider (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic               start,
	input  wire logic signed [31:0] dividend,
	input  wire logic        [31:0] divisor,
	output logic                    busy,
	output logic                    done,
	output logic signed [31:0]      quotient,
	output logic        [31:0]      remainder
);
	logic        busy_reg, busy_next, done_reg, done_next, neg_reg, neg_next;
	logic [5:0]  cnt_reg, cnt_next;
	logic [31:0] q_reg, q_next, den_reg, den_next, quot_reg, quot_next, rem_out_reg, rem_out_next;
	logic [32:0] r_reg, r_next, trial;

	// Restoring division, one bit per cycle, then a sign fix so results round toward minus.
	always_comb begin
		busy_next    = busy_reg;
		done_next    = 1'b0;
		neg_next     = neg_reg;
		cnt_next     = cnt_reg;
		q_next       = q_reg;
		r_next       = r_reg;
		den_next     = den_reg;
		quot_next    = quot_reg;
		rem_out_next = rem_out_reg;
		trial        = {r_reg[31:0], q_reg[31]};
		if (!busy_reg && start) begin
			busy_next = 1'b1;
			neg_next  = dividend[31];
			q_next    = dividend[31] ? 32'(-dividend) : 32'(dividend);
			r_next    = 33'h000000000;
			den_next  = divisor;
			cnt_next  = 6'h20;
		end else if (busy_reg && cnt_reg != 6'h00) begin
			cnt_next = cnt_reg - 6'h01;
			if (trial >= {1'b0, den_reg}) begin
				r_next = trial - {1'b0, den_reg};
				q_next = {q_reg[30:0], 1'b1};
			end else begin
				r_next = trial;
				q_next = {q_reg[30:0], 1'b0};
			end
		end else if (busy_reg) begin
			busy_next = 1'b0;
			done_next = 1'b1;
			if (neg_reg && r_reg != 33'h000000000) begin
				quot_next    = ~q_reg;
				rem_out_next = den_reg - r_reg[31:0];
			end else begin
				quot_next    = neg_reg ? 32'(-q_reg) : q_reg;
				rem_out_next = r_reg[31:0];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			busy_reg    <= 1'b0;
			done_reg    <= 1'b0;
			neg_reg     <= 1'b0;
			cnt_reg     <= 6'h00;
			q_reg       <= 32'h00000000;
			r_reg       <= 33'h000000000;
			den_reg     <= 32'h00000000;
			quot_reg    <= 32'h00000000;
			rem_out_reg <= 32'h00000000;
		end else begin
			busy_reg    <= busy_next;
			done_reg    <= done_next;
			neg_reg     <= neg_next;
			cnt_reg     <= cnt_next;
			q_reg       <= q_next;
			r_reg       <= r_next;
			den_reg     <= den_next;
			quot_reg    <= quot_next;
			rem_out_reg <= rem_out_next;
		end
	end

	assign busy      = busy_reg;
	assign done      = done_reg;
	assign quotient  = $signed(quot_reg);
	assign remainder = rem_out_reg;
endmodule // pos_divider

// File: hw/stepper_stage_positioner.sv
`timescale 1ns/1ps
// Function
// - Convert motion-unit move distance into microsteps.
// - Net microstep counter, up positive, down negative.
// - Report converts counter back into motion units.
// - Reset clears counter; axis starts unhomed.
// - Home: seek negative limit, offset, zero.
// - Linear stage stops when negative limit asserts.
// - Rotary stage moves through datum switch freely.
// - Rotary reports wrap into one revolution, 0 to below 200 units at reset values.
// - Moving current while stepping, holding when stationary.
// - Negative moves overshoot, then approach positively.
// - Backlash correction on after reset, can disable.
// - Positive direction means increasing absolute position.
module stepper_stage_positioner #(
	parameter logic [31:0] STEP_DIV_DEFAULT = 32'(positioner_pkg::STEP_DIV_CYCLES)
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        limit_neg_pin,
	output logic             step_pulse,
	output logic             step_dir,
	output logic             move_current,
	output logic             irq
);
	// Bus and register state.
	logic        aw_held_reg, aw_held_next, w_held_reg, w_held_next, bvalid_reg, bvalid_next;
	logic        rvalid_reg, rvalid_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [7:0]  awaddr_reg, awaddr_next;
	logic [3:0]  wstrb_reg, wstrb_next;
	logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic [31:0] cfg_reg, cfg_next, dist_reg, dist_next, spu_reg, spu_next;
	logic [31:0] backlash_reg, backlash_next, home_ofs_reg, home_ofs_next;
	logic [31:0] step_div_reg, step_div_next, rev_reg, rev_next;
	localparam int IRQ_W_L = positioner_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] irq_en_reg, irq_en_next, irq_stat_reg, irq_stat_next;
	logic        wr_fire, wr_ok, cmd_move, cmd_home, cmd_stop, cmd_report;
	logic [7:0]  wr_addr, rd_addr;

	// Step rate, limit sync, motion and report state.
	logic [31:0] rate_cnt_reg, rate_cnt_next;
	logic        tick;
	logic        lim_meta_reg, lim_sync_reg;
	positioner_pkg::motion_state_t mstate_reg, mstate_next;
	positioner_pkg::report_state_t rstate_reg, rstate_next;
	logic signed [31:0] pos_reg, pos_next, report_reg, report_next;
	logic [31:0] remain_reg, remain_next;
	logic        dir_reg, dir_next, leg2_reg, leg2_next, homed_reg, homed_next;
	logic        step_reg, step_next;
	logic        ev_move, ev_home, ev_limit, ev_report;
	logic signed [64:0] prod;
	logic signed [31:0] req_steps;
	logic [31:0] req_mag;
	logic        div_start, div_busy, div_done;
	logic signed [31:0] div_dividend, div_quot;
	logic [31:0] div_divisor, div_rem;
	logic        rotary;

	assign rotary = cfg_reg[positioner_pkg::CFG_ROTARY];

	// Merge a write into a register honouring the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = data[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Address and data are held separately, so either may arrive first.
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_addr       = awaddr_reg & 8'hFC;
	assign rd_addr       = s_axi_araddr & 8'hFC;
	assign cmd_move      = wr_fire && wr_addr == positioner_pkg::OFF_CTRL && wstrb_reg[0]
			&& wdata_reg[positioner_pkg::CTRL_MOVE];
	assign cmd_home      = wr_fire && wr_addr == positioner_pkg::OFF_CTRL && wstrb_reg[0]
			&& wdata_reg[positioner_pkg::CTRL_HOME];
	assign cmd_stop      = wr_fire && wr_addr == positioner_pkg::OFF_CTRL && wstrb_reg[0]
			&& wdata_reg[positioner_pkg::CTRL_STOP];
	assign cmd_report    = wr_fire && wr_addr == positioner_pkg::OFF_CTRL && wstrb_reg[0]
			&& wdata_reg[positioner_pkg::CTRL_REPORT];

	// Register file, write path, read path and sticky interrupt status.
	always_comb begin
		aw_held_next  = aw_held_reg;
		w_held_next   = w_held_reg;
		awaddr_next   = awaddr_reg;
		wdata_next    = wdata_reg;
		wstrb_next    = wstrb_reg;
		bvalid_next   = bvalid_reg && !s_axi_bready;
		bresp_next    = bresp_reg;
		rvalid_next   = rvalid_reg && !s_axi_rready;
		rresp_next    = rresp_reg;
		rdata_next    = rdata_reg;
		cfg_next      = cfg_reg;
		dist_next     = dist_reg;
		spu_next      = spu_reg;
		backlash_next = backlash_reg;
		home_ofs_next = home_ofs_reg;
		step_div_next = step_div_reg;
		rev_next      = rev_reg;
		irq_en_next   = irq_en_reg;
		irq_stat_next = irq_stat_reg;
		wr_ok         = 1'b1;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			awaddr_next  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next = 1'b1;
			wdata_next  = s_axi_wdata;
			wstrb_next  = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			unique case (wr_addr)
				positioner_pkg::OFF_CTRL: ;
				positioner_pkg::OFF_CFG: cfg_next = merge(cfg_reg, wdata_reg, wstrb_reg);
				positioner_pkg::OFF_MOVE_DIST: dist_next = merge(dist_reg, wdata_reg, wstrb_reg);
				positioner_pkg::OFF_STEPS_UNIT: spu_next = merge(spu_reg, wdata_reg, wstrb_reg);
				positioner_pkg::OFF_BACKLASH: backlash_next = merge(backlash_reg, wdata_reg, wstrb_reg);
				positioner_pkg::OFF_HOME_OFS: home_ofs_next = merge(home_ofs_reg, wdata_reg, wstrb_reg);
				positioner_pkg::OFF_STEP_DIV: step_div_next = merge(step_div_reg, wdata_reg, wstrb_reg);
				positioner_pkg::OFF_STEPS_REV: rev_next = merge(rev_reg, wdata_reg, wstrb_reg);
				positioner_pkg::OFF_IRQ_CLR: irq_stat_next = irq_stat_reg & ~wdata_reg[IRQ_W_L-1:0];
				positioner_pkg::OFF_IRQ_EN: irq_en_next = wdata_reg[IRQ_W_L-1:0];
				default: wr_ok = 1'b0;
			endcase
			bresp_next = wr_ok ? positioner_pkg::RESP_OKAY : positioner_pkg::RESP_SLVERR;
		end
		// Events are applied after the clear so a same-cycle event is never lost.
		irq_stat_next[positioner_pkg::IRQ_MOVE_DONE] |= ev_move;
		irq_stat_next[positioner_pkg::IRQ_HOME_DONE] |= ev_home;
		irq_stat_next[positioner_pkg::IRQ_LIMIT]     |= ev_limit;
		irq_stat_next[positioner_pkg::IRQ_REPORT]    |= ev_report;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next  = positioner_pkg::RESP_OKAY;
			unique case (rd_addr)
				positioner_pkg::OFF_CTRL, positioner_pkg::OFF_IRQ_CLR: rdata_next = 32'h00000000;
				positioner_pkg::OFF_CFG: rdata_next = cfg_reg;
				positioner_pkg::OFF_MOVE_DIST: rdata_next = dist_reg;
				positioner_pkg::OFF_STEPS_UNIT: rdata_next = spu_reg;
				positioner_pkg::OFF_BACKLASH: rdata_next = backlash_reg;
				positioner_pkg::OFF_HOME_OFS: rdata_next = home_ofs_reg;
				positioner_pkg::OFF_STEP_DIV: rdata_next = step_div_reg;
				positioner_pkg::OFF_STEPS_REV: rdata_next = rev_reg;
				positioner_pkg::OFF_POSITION: rdata_next = pos_reg;
				positioner_pkg::OFF_REPORT: rdata_next = report_reg;
				positioner_pkg::OFF_STATUS: rdata_next = {27'h0000000, dir_reg, lim_sync_reg,
						rstate_reg != positioner_pkg::REP_IDLE, homed_reg,
						mstate_reg != positioner_pkg::MOT_IDLE};
				positioner_pkg::OFF_IRQ_STAT: rdata_next = {28'h0000000, irq_stat_reg};
				positioner_pkg::OFF_IRQ_EN: rdata_next = {28'h0000000, irq_en_reg};
				default: begin
					rdata_next = 32'h00000000;
					rresp_next = positioner_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			awaddr_reg   <= 8'h00;
			wdata_reg    <= 32'h00000000;
			wstrb_reg    <= 4'h0;
			bvalid_reg   <= 1'b0;
			bresp_reg    <= 2'h0;
			rvalid_reg   <= 1'b0;
			rresp_reg    <= 2'h0;
			rdata_reg    <= 32'h00000000;
			cfg_reg      <= positioner_pkg::CFG_RESET;
			dist_reg     <= 32'h00000000;
			spu_reg      <= positioner_pkg::STEPS_UNIT_RESET;
			backlash_reg <= positioner_pkg::BACKLASH_RESET;
			home_ofs_reg <= positioner_pkg::HOME_OFS_RESET;
			step_div_reg <= STEP_DIV_DEFAULT;
			rev_reg      <= positioner_pkg::STEPS_REV_RESET;
			irq_en_reg   <= 4'h0;
			irq_stat_reg <= 4'h0;
		end else begin
			aw_held_reg  <= aw_held_next;
			w_held_reg   <= w_held_next;
			awaddr_reg   <= awaddr_next;
			wdata_reg    <= wdata_next;
			wstrb_reg    <= wstrb_next;
			bvalid_reg   <= bvalid_next;
			bresp_reg    <= bresp_next;
			rvalid_reg   <= rvalid_next;
			rresp_reg    <= rresp_next;
			rdata_reg    <= rdata_next;
			cfg_reg      <= cfg_next;
			dist_reg     <= dist_next;
			spu_reg      <= spu_next;
			backlash_reg <= backlash_next;
			home_ofs_reg <= home_ofs_next;
			step_div_reg <= step_div_next;
			rev_reg      <= rev_next;
			irq_en_reg   <= irq_en_next;
			irq_stat_reg <= irq_stat_next;
		end
	end

	// Free-running step rate divider; a zero divisor steps on every cycle.
	assign tick = (rate_cnt_reg == 32'h00000000);
	always_comb begin
		rate_cnt_next = tick ? ((step_div_reg == 32'h00000000) ? 32'h00000000
				: step_div_reg - 32'h00000001) : rate_cnt_reg - 32'h00000001;
	end

	// The limit switch is asynchronous; only the second flop is used.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rate_cnt_reg <= 32'h00000000;
			lim_meta_reg <= 1'b0;
			lim_sync_reg <= 1'b0;
		end else begin
			rate_cnt_reg <= rate_cnt_next;
			lim_meta_reg <= limit_neg_pin;
			lim_sync_reg <= lim_meta_reg;
		end
	end

	// Distance in units times microsteps per unit; overflow wraps, so keep moves sane.
	assign prod      = $signed(dist_reg) * $signed({1'b0, spu_reg});
	assign req_steps = prod[31:0];
	assign req_mag   = req_steps[31] ? 32'(-req_steps) : 32'(req_steps);

	// Motion sequencer: moves, backlash legs, homing and limit stops.
	always_comb begin
		mstate_next = mstate_reg;
		pos_next    = pos_reg;
		remain_next = remain_reg;
		dir_next    = dir_reg;
		leg2_next   = leg2_reg;
		homed_next  = homed_reg;
		step_next   = 1'b0;
		ev_move     = 1'b0;
		ev_home     = 1'b0;
		ev_limit    = 1'b0;
		unique case (mstate_reg)
			positioner_pkg::MOT_IDLE: begin
				if (cmd_home) begin
					mstate_next = positioner_pkg::MOT_SEEK;
					dir_next    = 1'b0;
				end else if (cmd_move) begin
					mstate_next = positioner_pkg::MOT_MOVE;
					if (!req_steps[31] || !cfg_reg[positioner_pkg::CFG_BACKLASH]) begin
						remain_next = req_mag;
						dir_next    = !req_steps[31];
						leg2_next   = 1'b0;
					end else begin
						remain_next = req_mag + backlash_reg;
						dir_next    = 1'b0;
						leg2_next   = (backlash_reg != 32'h00000000);
					end
				end
			end
			positioner_pkg::MOT_MOVE: begin
				if (!rotary && !dir_reg && lim_sync_reg) begin
					mstate_next = positioner_pkg::MOT_IDLE;
					ev_limit    = 1'b1;
				end else if (remain_reg == 32'h00000000) begin
					if (leg2_reg) begin
						remain_next = backlash_reg;
						dir_next    = 1'b1;
						leg2_next   = 1'b0;
					end else begin
						mstate_next = positioner_pkg::MOT_IDLE;
						ev_move     = 1'b1;
					end
				end else if (tick) begin
					step_next   = 1'b1;
					remain_next = remain_reg - 32'h00000001;
					pos_next    = dir_reg ? pos_reg + 32'sh1 : pos_reg - 32'sh1;
				end
			end
			positioner_pkg::MOT_SEEK: begin
				if (lim_sync_reg) begin
					mstate_next = positioner_pkg::MOT_OFFSET;
					remain_next = home_ofs_reg;
					dir_next    = 1'b1;
				end else if (tick) begin
					step_next = 1'b1;
					pos_next  = pos_reg - 32'sh1;
				end
			end
			positioner_pkg::MOT_OFFSET: begin
				if (remain_reg == 32'h00000000) begin
					mstate_next = positioner_pkg::MOT_IDLE;
					pos_next    = 32'sh0;
					homed_next  = 1'b1;
					ev_home     = 1'b1;
				end else if (tick) begin
					step_next   = 1'b1;
					remain_next = remain_reg - 32'h00000001;
					pos_next    = pos_reg + 32'sh1;
				end
			end
		endcase
		// Stop abandons any sequence; an interrupted home leaves the axis unhomed.
		if (cmd_stop && mstate_reg != positioner_pkg::MOT_IDLE) begin
			mstate_next = positioner_pkg::MOT_IDLE;
			step_next   = 1'b0;
			if (mstate_reg != positioner_pkg::MOT_MOVE) begin
				homed_next = 1'b0;
			end
		end
		if (cmd_home && mstate_reg == positioner_pkg::MOT_IDLE) begin
			homed_next = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mstate_reg <= positioner_pkg::MOT_IDLE;
			pos_reg    <= 32'sh0;
			remain_reg <= 32'h00000000;
			dir_reg    <= 1'b1;
			leg2_reg   <= 1'b0;
			homed_reg  <= 1'b0;
			step_reg   <= 1'b0;
		end else begin
			mstate_reg <= mstate_next;
			pos_reg    <= pos_next;
			remain_reg <= remain_next;
			dir_reg    <= dir_next;
			leg2_reg   <= leg2_next;
			homed_reg  <= homed_next;
			step_reg   <= step_next;
		end
	end

	// Report: rotary first wraps into one revolution, then scales to units.
	always_comb begin
		rstate_next  = rstate_reg;
		report_next  = report_reg;
		div_start    = 1'b0;
		div_dividend = pos_reg;
		div_divisor  = spu_reg;
		ev_report    = 1'b0;
		unique case (rstate_reg)
			positioner_pkg::REP_IDLE: begin
				if (cmd_report && !div_busy) begin
					div_start   = 1'b1;
					div_divisor = rotary ? rev_reg : spu_reg;
					rstate_next = rotary ? positioner_pkg::REP_WRAP : positioner_pkg::REP_SCALE;
				end
			end
			positioner_pkg::REP_WRAP: begin
				if (div_done) begin
					div_start    = 1'b1;
					div_dividend = $signed(div_rem);
					rstate_next  = positioner_pkg::REP_SCALE;
				end
			end
			positioner_pkg::REP_SCALE: begin
				if (div_done) begin
					report_next = div_quot;
					rstate_next = positioner_pkg::REP_IDLE;
					ev_report   = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rstate_reg <= positioner_pkg::REP_IDLE;
			report_reg <= 32'sh0;
		end else begin
			rstate_reg <= rstate_next;
			report_reg <= report_next;
		end
	end

	pos_divider u_div (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.start     (div_start),
		.dividend  (div_dividend),
		.divisor   (div_divisor),
		.busy      (div_busy),
		.done      (div_done),
		.quotient  (div_quot),
		.remainder (div_rem)
	);

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;
	assign step_pulse   = step_reg;
	assign step_dir     = dir_reg;
	assign move_current = (mstate_reg != positioner_pkg::MOT_IDLE);
	assign irq          = |(irq_stat_reg & irq_en_reg);
endmodule // stepper_stage_positioner

// File: verif/stage_model.sv
`timescale 1ns/1ps
// Stage whose negative limit switch is closed at and below position zero.
module stage_model #(
	parameter int START = 20
) (
	input  wire logic clk_sys,
	input  wire logic step_pulse,
	input  wire logic step_dir,
	output logic      limit_neg_pin
);
	int pos = START;
	// One microstep per pulse; the switch is clean, so any bounce is untested.
	always @(posedge clk_sys) begin
		if (step_pulse) pos <= pos + (step_dir ? 1 : -1);
	end
	assign limit_neg_pin = (pos <= 0);
endmodule // stage_model

// File: verif/stepper_stage_positioner_monitor.sv
`timescale 1ns/1ps
// Watches drive outputs and bus handshakes; register state is not visible here.
module stepper_stage_positioner_monitor (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic step_pulse,
	input wire logic step_dir,
	input wire logic move_current
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Steps need moving current and stay single pulses; idle means quiet.
	a_step_current: assert property (step_pulse |-> move_current)
		else $error("step at holding current");
	a_step_single: assert property (step_pulse |=> !step_pulse)
		else $error("step pulse too long");
	a_idle_quiet: assert property ($fell(move_current) |-> (!step_pulse)[*3])
		else $error("step after idle");
	a_reset_idle: assert property ($fell(rst) |-> !move_current && step_dir)
		else $error("axis busy after reset");

	// Bus answers come at the promised cycle and block new requests.
	a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
endmodule // stepper_stage_positioner_monitor

bind stepper_stage_positioner stepper_stage_positioner_monitor monitor_inst (.clk_sys, .rst,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .step_pulse, .step_dir, .move_current);

// File: verif/tb_stepper_stage_positioner.sv
`timescale 1ns/1ps
// Bus tasks note expected read data; a watcher compares it as answers arrive.
module tb_stepper_stage_positioner;
	logic        clk_sys = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, seed = 32'h11, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        limit_neg_pin, step_pulse, step_dir, move_current, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [33:0] exp_q[$], msk_q[$];
	int          n_errors = 0, n_compared = 0, nsteps = 0, p = 0, d;
	logic [7:0]  ra[6] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20};
	logic [31:0] rv[6] = '{positioner_pkg::CFG_RESET, positioner_pkg::STEPS_UNIT_RESET,
		positioner_pkg::BACKLASH_RESET, positioner_pkg::HOME_OFS_RESET,
		positioner_pkg::STEPS_REV_RESET, 32'h0};

	// A short step divider keeps every move to a few hundred cycles.
	always #25 clk_sys = ~clk_sys;
	stepper_stage_positioner #(.STEP_DIV_DEFAULT(32'h4)) stepper_stage_positioner_inst (.clk_sys,
		.rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .limit_neg_pin, .step_pulse, .step_dir, .move_current, .irq);
	stage_model stage_model_inst (.clk_sys, .step_pulse, .step_dir, .limit_neg_pin);

	// Steps are counted so each move shows its overshoot; reads meet their notes.
	always @(negedge clk_sys) begin
		if (step_pulse) nsteps++;
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata} & msk_q.pop_front(), exp_q.pop_front());
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [33:0] got, input logic [33:0] want);
		n_compared++;
		if (got !== want) begin
			n_errors++;
			$display("mismatch at %0t got %h want %h", $time, got, want);
		end
	endtask

	task automatic give_verdict();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic fail();
		n_errors++;
		give_verdict();
	endtask

	// Handshakes are sampled at the falling edge, when the ready lines are settled.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = 2'h0);
		logic aw, w, b;
		b = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (int n = 0; n < 99 && !b; n++) begin
			@(negedge clk_sys);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			if (b) chk(34'(s_axi_bresp), 34'(r));
			@(posedge clk_sys);
			if (aw) s_axi_awvalid <= 0;
			if (w) s_axi_wvalid <= 0;
			if (b) s_axi_bready <= 0;
		end
		if (!b) fail();
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] r = 2'h0);
		logic ar, v;
		v = 0;
		msk_q.push_back({2'h3, m});
		exp_q.push_back({r, e & m});
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (int n = 0; n < 99 && !v; n++) begin
			@(negedge clk_sys);
			ar = s_axi_arready;
			v = s_axi_rvalid;
			@(posedge clk_sys);
			if (ar) s_axi_arvalid <= 0;
			if (v) s_axi_rready <= 0;
		end
		if (!v) fail();
	endtask

	task automatic wirq();
		for (int n = 0; n < 9999 && !irq; n++) @(negedge clk_sys);
		if (!irq) fail();
	endtask

	// A relative move, then its step count, position and done event are checked.
	task automatic mv(input int u, input int xs);
		wr(8'h08, u);
		nsteps = 0;
		wr(8'h00, 32'h1);
		wirq();
		p += u * 4;
		chk(34'(nsteps), 34'(xs));
		chk(34'(move_current), 34'h0);
		chk(34'(stage_model_inst.pos - p), 34'h3);
		rd(8'h2C, 32'h1, '1);
		rd(8'h20, p, '1);
		wr(8'h30, 32'hF);
	endtask

	task automatic rep(input int e);
		wr(8'h00, 32'h8);
		wirq();
		rd(8'h24, e, '1);
		wr(8'h30, 32'hF);
	endtask

	// Main sequence: reset values, homing, random moves, rotary wrap, limit stop.
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 0;
		foreach (ra[i]) rd(ra[i], rv[i], '1);
		rd(8'h28, 32'h0, 32'h2);
		rd(8'h3C, 32'h0, '1, 2'h2);
		wr(8'h3C, 32'h0, 2'h2);
		wr(8'h0C, 32'h4);
		wr(8'h10, 32'h2);
		wr(8'h14, 32'h3);
		wr(8'h34, 32'hF);
		wr(8'h00, 32'h2);
		wirq();
		rd(8'h2C, 32'h2, '1);
		rd(8'h20, 32'h0, '1);
		rd(8'h28, 32'h2, 32'h3);
		wr(8'h30, 32'hF);
		mv(5, 20);
		for (int i = 0; i < 6; i++) begin
			d = int'(rnd() % 7) - 3;
			if (d == 0 || p + d * 4 < 12) d = 2;
			wr(8'h04, 32'(i % 2));
			mv(d, (d < 0 ? -d * 4 : d * 4) + ((d < 0 && i % 2) ? 4 : 0));
		end
		rep(p / 4);
		wr(8'h1C, 32'd40);
		wr(8'h04, 32'h2);
		mv(-(p / 4) - 3, p + 12);
		rep(7);
		mv(8, 32);
		wr(8'h04, 32'h0);
		wr(8'h08, -10);
		wr(8'h00, 32'h1);
		wirq();
		rd(8'h2C, 32'h4, '1);
		wr(8'h34, 32'h0);
		chk(34'(irq), 34'h0);
		wr(8'h34, 32'hF);
		chk(34'(irq), 34'h1);
		wr(8'h30, 32'hF);
		chk(34'(irq), 34'h0);
		wr(8'h08, 32'h5);
		wr(8'h00, 32'h1);
		wr(8'h00, 32'h4);
		rd(8'h28, 32'h0, 32'h1);
		chk(34'(move_current), 34'h0);
		give_verdict();
	end
endmodule // tb_stepper_stage_positioner
